// ---- include/cafr_pkg.sv ----
// Package: register map, field masks, reset values and carrier types
package cafr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SECONDS = 8'h08;
  localparam logic [7:0] OFF_MINUTES = 8'h0c;
  localparam logic [7:0] OFF_HOURS = 8'h10;
  localparam logic [7:0] OFF_WEEKDAY = 8'h14;
  localparam logic [7:0] OFF_MONTHDAY = 8'h18;
  localparam logic [7:0] OFF_MONTH = 8'h1c;
  localparam logic [7:0] OFF_YEAR = 8'h20;
  localparam logic [7:0] OFF_ALARM_MINUTES = 8'h24;
  localparam logic [7:0] OFF_ALARM_HOURS = 8'h28;
  localparam logic [7:0] OFF_ALARM_WEEKDAY = 8'h2c;
  localparam logic [7:0] OFF_ALARM_MONTHDAY = 8'h30;

  // Control, status and alarm-enable bit positions
  localparam int CTRL_DECIMAL_BIT = 0;
  localparam int CTRL_CALENDAR_BIT = 1;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_MATCH_BIT = 1;
  localparam int ALARM_ENABLE_BIT = 7;

  // Writable/readable masks, binary and packed-decimal views
  localparam logic [15:0] MSK_SEC_BIN = 16'h003f;
  localparam logic [15:0] MSK_SEC_DEC = 16'h007f;
  localparam logic [15:0] MSK_MIN_BIN = 16'h003f;
  localparam logic [15:0] MSK_MIN_DEC = 16'h007f;
  localparam logic [15:0] MSK_HOUR_BIN = 16'h001f;
  localparam logic [15:0] MSK_HOUR_DEC = 16'h003f;
  localparam logic [15:0] MSK_DOW = 16'h0007;
  localparam logic [15:0] MSK_DAY_BIN = 16'h001f;
  localparam logic [15:0] MSK_DAY_DEC = 16'h003f;
  localparam logic [15:0] MSK_MON_BIN = 16'h000f;
  localparam logic [15:0] MSK_MON_DEC = 16'h001f;
  localparam logic [15:0] MSK_YEAR_BIN = 16'h0fff;
  localparam logic [15:0] MSK_YEAR_DEC = 16'h7fff;
  localparam logic [15:0] MSK_ALARM_EN = 16'h0080;

  // Reset values
  localparam logic RST_DECIMAL = 1'b0;
  localparam logic RST_CALENDAR = 1'b1;
  localparam logic [7:0] RST_FIELD = 8'h00;
  localparam logic [15:0] RST_YEAR = 16'h0000;

  typedef struct packed {
    logic [7:0] seconds_field_reg;
    logic [7:0] minutes_field_reg;
    logic [7:0] hours_field_reg;
    logic [7:0] weekday_field_reg;
    logic [7:0] monthday_field_reg;
    logic [7:0] month_field_reg;
    logic [15:0] year_field_reg;
  } cafr_time_t;

  typedef struct packed {
    logic [7:0] alarm_minutes_reg;
    logic [7:0] alarm_hours_reg;
    logic [7:0] alarm_weekday_reg;
    logic [7:0] alarm_monthday_reg;
  } cafr_alarm_t;

  typedef struct packed {
    cafr_time_t cal;
    cafr_alarm_t alm;
    logic decimal_format_select;
    logic calendar_select;
    logic alarm_flag;
    logic match_d;
    logic event_p;
    logic [31:0] prdata;
    logic pslverr;
  } cafr_state_t;

endpackage

// ---- hw/cafr_regs.sv ----
// Calendar and alarm field registers with APB slave and alarm matcher
`timescale 1ns/1ps
`default_nettype none

module cafr_regs
  import cafr_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CNT_LOAD,
  input wire cafr_time_t CNT_TIME,
  output cafr_time_t CAL_TIME,
  output logic DECIMAL_MODE,
  output logic CALENDAR_MODE,
  output logic ALARM_MATCH,
  output logic ALARM_EVENT
);

  cafr_state_t state_reg;
  cafr_state_t state_next;
  logic dec_eff;
  logic setup_phase;
  logic write_access;
  logic [15:0] lane_mask;
  logic match_now;
  logic any_enabled;
  logic all_match;
  logic min_ok;
  logic hour_ok;
  logic dow_ok;
  logic day_ok;
  logic [7:0] sec_load;
  logic [7:0] min_load;
  logic [7:0] hour_load;
  logic [7:0] dow_load;
  logic [7:0] day_load;
  logic [7:0] mon_load;
  logic [15:0] year_load;

  // Field mask for an offset in the selected format
  function automatic logic [15:0] field_mask(input logic [7:0] off, input logic dec);
    logic [15:0] m;
    m = 16'h0000;
    unique case (off)
      OFF_SECONDS: m = dec ? MSK_SEC_DEC : MSK_SEC_BIN;
      OFF_MINUTES: m = dec ? MSK_MIN_DEC : MSK_MIN_BIN;
      OFF_HOURS: m = dec ? MSK_HOUR_DEC : MSK_HOUR_BIN;
      OFF_WEEKDAY: m = MSK_DOW;
      OFF_MONTHDAY: m = dec ? MSK_DAY_DEC : MSK_DAY_BIN;
      OFF_MONTH: m = dec ? MSK_MON_DEC : MSK_MON_BIN;
      OFF_YEAR: m = dec ? MSK_YEAR_DEC : MSK_YEAR_BIN;
      OFF_ALARM_MINUTES: m = MSK_ALARM_EN | (dec ? MSK_MIN_DEC : MSK_MIN_BIN);
      OFF_ALARM_HOURS: m = MSK_ALARM_EN | (dec ? MSK_HOUR_DEC : MSK_HOUR_BIN);
      OFF_ALARM_WEEKDAY: m = MSK_ALARM_EN | MSK_DOW;
      OFF_ALARM_MONTHDAY: m = MSK_ALARM_EN | (dec ? MSK_DAY_DEC : MSK_DAY_BIN);
      default: m = 16'h0000;
    endcase
    return m;
  endfunction

  // Offset decode
  function automatic logic is_mapped(input logic [7:0] off);
    logic hit;
    hit = 1'b0;
    unique case (off)
      OFF_CTRL, OFF_STATUS, OFF_SECONDS, OFF_MINUTES, OFF_HOURS, OFF_WEEKDAY,
      OFF_MONTHDAY, OFF_MONTH, OFF_YEAR, OFF_ALARM_MINUTES, OFF_ALARM_HOURS,
      OFF_ALARM_WEEKDAY, OFF_ALARM_MONTHDAY: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Raw stored value of a field register
  function automatic logic [15:0] raw_field(input logic [7:0] off, input cafr_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    unique case (off)
      OFF_SECONDS: v = {8'h00, s.cal.seconds_field_reg};
      OFF_MINUTES: v = {8'h00, s.cal.minutes_field_reg};
      OFF_HOURS: v = {8'h00, s.cal.hours_field_reg};
      OFF_WEEKDAY: v = {8'h00, s.cal.weekday_field_reg};
      OFF_MONTHDAY: v = {8'h00, s.cal.monthday_field_reg};
      OFF_MONTH: v = {8'h00, s.cal.month_field_reg};
      OFF_YEAR: v = s.cal.year_field_reg;
      OFF_ALARM_MINUTES: v = {8'h00, s.alm.alarm_minutes_reg};
      OFF_ALARM_HOURS: v = {8'h00, s.alm.alarm_hours_reg};
      OFF_ALARM_WEEKDAY: v = {8'h00, s.alm.alarm_weekday_reg};
      OFF_ALARM_MONTHDAY: v = {8'h00, s.alm.alarm_monthday_reg};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // Software view: stored bits seen through the current format
  function automatic logic [31:0] read_view(input logic [7:0] off, input cafr_state_t s,
                                            input logic dec);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (off == OFF_CTRL) begin
      r[CTRL_DECIMAL_BIT] = s.decimal_format_select;
      r[CTRL_CALENDAR_BIT] = s.calendar_select;
    end else if (off == OFF_STATUS) begin
      r[STAT_FLAG_BIT] = s.alarm_flag;
      r[STAT_MATCH_BIT] = s.match_d;
    end else begin
      r = {16'h0000, raw_field(off, s) & field_mask(off, dec)};
    end
    return r;
  endfunction

  assign dec_eff = state_reg.decimal_format_select & state_reg.calendar_select;
  assign setup_phase = PSEL & ~PENABLE;
  assign write_access = PSEL & PENABLE & PWRITE;
  assign lane_mask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};

  // Per-field alarm comparators
  cafr_field_cmp #(
    .FIELD_W(8)
  ) min_cmp_u (
    .alarm_val(state_reg.alm.alarm_minutes_reg),
    .cal_val(state_reg.cal.minutes_field_reg),
    .cmp_mask(8'(field_mask(OFF_ALARM_MINUTES, dec_eff) & ~MSK_ALARM_EN)),
    .enable(state_reg.alm.alarm_minutes_reg[ALARM_ENABLE_BIT]),
    .field_ok(min_ok)
  );
  cafr_field_cmp #(
    .FIELD_W(8)
  ) hour_cmp_u (
    .alarm_val(state_reg.alm.alarm_hours_reg),
    .cal_val(state_reg.cal.hours_field_reg),
    .cmp_mask(8'(field_mask(OFF_ALARM_HOURS, dec_eff) & ~MSK_ALARM_EN)),
    .enable(state_reg.alm.alarm_hours_reg[ALARM_ENABLE_BIT]),
    .field_ok(hour_ok)
  );
  cafr_field_cmp #(
    .FIELD_W(8)
  ) dow_cmp_u (
    .alarm_val(state_reg.alm.alarm_weekday_reg),
    .cal_val(state_reg.cal.weekday_field_reg),
    .cmp_mask(8'(field_mask(OFF_ALARM_WEEKDAY, dec_eff) & ~MSK_ALARM_EN)),
    .enable(state_reg.alm.alarm_weekday_reg[ALARM_ENABLE_BIT]),
    .field_ok(dow_ok)
  );
  cafr_field_cmp #(
    .FIELD_W(8)
  ) day_cmp_u (
    .alarm_val(state_reg.alm.alarm_monthday_reg),
    .cal_val(state_reg.cal.monthday_field_reg),
    .cmp_mask(8'(field_mask(OFF_ALARM_MONTHDAY, dec_eff) & ~MSK_ALARM_EN)),
    .enable(state_reg.alm.alarm_monthday_reg[ALARM_ENABLE_BIT]),
    .field_ok(day_ok)
  );

  // Counter load values cut to the current format
  cafr_load_mask #(
    .FIELD_W(8)
  ) sec_load_u (
    .raw_val(CNT_TIME.seconds_field_reg),
    .keep_mask(8'(field_mask(OFF_SECONDS, dec_eff))),
    .kept_val(sec_load)
  );
  cafr_load_mask #(
    .FIELD_W(8)
  ) min_load_u (
    .raw_val(CNT_TIME.minutes_field_reg),
    .keep_mask(8'(field_mask(OFF_MINUTES, dec_eff))),
    .kept_val(min_load)
  );
  cafr_load_mask #(
    .FIELD_W(8)
  ) hour_load_u (
    .raw_val(CNT_TIME.hours_field_reg),
    .keep_mask(8'(field_mask(OFF_HOURS, dec_eff))),
    .kept_val(hour_load)
  );
  cafr_load_mask #(
    .FIELD_W(8)
  ) dow_load_u (
    .raw_val(CNT_TIME.weekday_field_reg),
    .keep_mask(8'(field_mask(OFF_WEEKDAY, dec_eff))),
    .kept_val(dow_load)
  );
  cafr_load_mask #(
    .FIELD_W(8)
  ) day_load_u (
    .raw_val(CNT_TIME.monthday_field_reg),
    .keep_mask(8'(field_mask(OFF_MONTHDAY, dec_eff))),
    .kept_val(day_load)
  );
  cafr_load_mask #(
    .FIELD_W(8)
  ) mon_load_u (
    .raw_val(CNT_TIME.month_field_reg),
    .keep_mask(8'(field_mask(OFF_MONTH, dec_eff))),
    .kept_val(mon_load)
  );
  cafr_load_mask #(
    .FIELD_W(16)
  ) year_load_u (
    .raw_val(CNT_TIME.year_field_reg),
    .keep_mask(field_mask(OFF_YEAR, dec_eff)),
    .kept_val(year_load)
  );

  // Alarm comparison on the present calendar
  always_comb begin
    any_enabled = state_reg.alm.alarm_minutes_reg[ALARM_ENABLE_BIT]
                | state_reg.alm.alarm_hours_reg[ALARM_ENABLE_BIT]
                | state_reg.alm.alarm_weekday_reg[ALARM_ENABLE_BIT]
                | state_reg.alm.alarm_monthday_reg[ALARM_ENABLE_BIT];
    all_match = min_ok & hour_ok & dow_ok & day_ok;
    match_now = any_enabled & all_match;
  end

  // Next state
  always_comb begin
    logic [15:0] merged;
    merged = 16'h0000;
    state_next = state_reg;
    state_next.event_p = 1'b0;

    // Load from the counting logic, seen through the current format
    if (CNT_LOAD) begin
      state_next.cal.seconds_field_reg = sec_load;
      state_next.cal.minutes_field_reg = min_load;
      state_next.cal.hours_field_reg = hour_load;
      state_next.cal.weekday_field_reg = dow_load;
      state_next.cal.monthday_field_reg = day_load;
      state_next.cal.month_field_reg = mon_load;
      state_next.cal.year_field_reg = year_load;
    end

    // Setup phase captures read data and error
    if (setup_phase) begin
      state_next.pslverr = ~is_mapped(PADDR);
      state_next.prdata = (PWRITE || !is_mapped(PADDR)) ? 32'h0000_0000
                                                        : read_view(PADDR, state_reg, dec_eff);
    end

    // Software write wins over a counter load on the same register
    if (write_access && is_mapped(PADDR)) begin
      merged = (raw_field(PADDR, state_reg) & ~lane_mask) | (PWDATA[15:0] & lane_mask);
      merged = merged & field_mask(PADDR, dec_eff);
      unique case (PADDR)
        OFF_CTRL: begin
          if (PSTRB[0]) begin
            state_next.decimal_format_select = PWDATA[CTRL_DECIMAL_BIT];
            state_next.calendar_select = PWDATA[CTRL_CALENDAR_BIT];
          end
        end
        OFF_STATUS: begin
          if (PSTRB[0] && PWDATA[STAT_FLAG_BIT]) begin
            state_next.alarm_flag = 1'b0;
          end
        end
        OFF_SECONDS: state_next.cal.seconds_field_reg = merged[7:0];
        OFF_MINUTES: state_next.cal.minutes_field_reg = merged[7:0];
        OFF_HOURS: state_next.cal.hours_field_reg = merged[7:0];
        OFF_WEEKDAY: state_next.cal.weekday_field_reg = merged[7:0];
        OFF_MONTHDAY: state_next.cal.monthday_field_reg = merged[7:0];
        OFF_MONTH: state_next.cal.month_field_reg = merged[7:0];
        OFF_YEAR: state_next.cal.year_field_reg = merged;
        OFF_ALARM_MINUTES: state_next.alm.alarm_minutes_reg = merged[7:0];
        OFF_ALARM_HOURS: state_next.alm.alarm_hours_reg = merged[7:0];
        OFF_ALARM_WEEKDAY: state_next.alm.alarm_weekday_reg = merged[7:0];
        OFF_ALARM_MONTHDAY: state_next.alm.alarm_monthday_reg = merged[7:0];
        default: state_next.pslverr = state_reg.pslverr;
      endcase
    end

    // Rising match raises the event; set beats a clear in the same cycle
    state_next.match_d = match_now;
    if (match_now && !state_reg.match_d) begin
      state_next.event_p = 1'b1;
      state_next.alarm_flag = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg.cal.seconds_field_reg <= RST_FIELD;
      state_reg.cal.minutes_field_reg <= RST_FIELD;
      state_reg.cal.hours_field_reg <= RST_FIELD;
      state_reg.cal.weekday_field_reg <= RST_FIELD;
      state_reg.cal.monthday_field_reg <= RST_FIELD;
      state_reg.cal.month_field_reg <= RST_FIELD;
      state_reg.cal.year_field_reg <= RST_YEAR;
      state_reg.alm.alarm_minutes_reg <= RST_FIELD;
      state_reg.alm.alarm_hours_reg <= RST_FIELD;
      state_reg.alm.alarm_weekday_reg <= RST_FIELD;
      state_reg.alm.alarm_monthday_reg <= RST_FIELD;
      state_reg.decimal_format_select <= RST_DECIMAL;
      state_reg.calendar_select <= RST_CALENDAR;
      state_reg.alarm_flag <= 1'b0;
      state_reg.match_d <= 1'b0;
      state_reg.event_p <= 1'b0;
      state_reg.prdata <= 32'h0000_0000;
      state_reg.pslverr <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign PREADY = 1'b1;
  assign PRDATA = state_reg.prdata;
  assign PSLVERR = state_reg.pslverr & PSEL & PENABLE;
  assign DECIMAL_MODE = dec_eff;
  assign CALENDAR_MODE = state_reg.calendar_select;
  assign ALARM_MATCH = state_reg.match_d;
  assign ALARM_EVENT = state_reg.event_p;
  assign CAL_TIME = state_reg.cal;

endmodule

// Alarm field comparator; a disabled field always agrees
module cafr_field_cmp #(
  parameter int FIELD_W = 8
) (
  input wire logic [FIELD_W-1:0] alarm_val,
  input wire logic [FIELD_W-1:0] cal_val,
  input wire logic [FIELD_W-1:0] cmp_mask,
  input wire logic enable,
  output logic field_ok
);
  assign field_ok = !enable || ((alarm_val & cmp_mask) == (cal_val & cmp_mask));
endmodule

// Counter load value cut to the bits of the current format
module cafr_load_mask #(
  parameter int FIELD_W = 8
) (
  input wire logic [FIELD_W-1:0] raw_val,
  input wire logic [FIELD_W-1:0] keep_mask,
  output logic [FIELD_W-1:0] kept_val
);
  assign kept_val = raw_val & keep_mask;
endmodule

`default_nettype wire

// ---- sim/cafr_regs_chk.sv ----
// Port checker for the calendar and alarm field registers
`timescale 1ns/1ps
`default_nettype none
module cafr_regs_chk
  import cafr_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  input wire logic CNT_LOAD,
  input wire cafr_time_t CNT_TIME,
  input wire cafr_time_t CAL_TIME,
  input wire logic DECIMAL_MODE,
  input wire logic CALENDAR_MODE,
  input wire logic ALARM_MATCH,
  input wire logic ALARM_EVENT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence rd_setup_s(logic [7:0] a);
    PSEL && !PENABLE && !PWRITE && PADDR == a ##1 PSEL && PENABLE;
  endsequence
  sequence load_s;
    CNT_LOAD && !(PSEL && PENABLE && PWRITE);
  endsequence
  upper_zero_a: assert property (PSEL && PENABLE |-> PRDATA[31:16] == 16'h0)
    else $error("upper read bits set");
  misalign_err_a: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0 |=> PSLVERR)
    else $error("misaligned access not refused");
  fmt_gate_a: assert property (DECIMAL_MODE |-> CALENDAR_MODE)
    else $error("decimal outside calendar mode");
  cal_zero_a: assert property (!CAL_TIME.seconds_field_reg[7] && !CAL_TIME.year_field_reg[15]
    && CAL_TIME.hours_field_reg[7:6] == 2'h0 && CAL_TIME.month_field_reg[7:5] == 3'h0)
    else $error("always-zero stored bit set");
  dow_load_a: assert property (load_s |=>
    CAL_TIME.weekday_field_reg == {5'h0, $past(CNT_TIME.weekday_field_reg[2:0])})
    else $error("weekday load wrong");
  dow_read_a: assert property (rd_setup_s(OFF_WEEKDAY) |-> PRDATA[7:3] == 5'h0)
    else $error("weekday high bits read set");
  sec_read_a: assert property (rd_setup_s(OFF_SECONDS) |-> !PRDATA[7])
    else $error("seconds bit 7 read set");
  event_rise_a: assert property (ALARM_EVENT == $rose(ALARM_MATCH))
    else $error("event not on match rise");
  event_once_a: assert property (ALARM_EVENT |=> !ALARM_EVENT)
    else $error("event longer than one cycle");
endmodule
bind cafr_regs cafr_regs_chk chk_u (.*);
`default_nettype wire

// ---- sim/calendar_alarm_field_registers_tb_top.sv ----
// Self-checking bench for the calendar and alarm field registers
`timescale 1ns/1ps
`default_nettype none
module calendar_alarm_field_registers_tb_top
  import cafr_pkg::*;
;
  logic ref_clk, rst_n, psel, penable, pwrite, cnt_load, pready, pslverr, err;
  logic dec_mode, cal_mode, a_match, a_event;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  cafr_time_t cnt_time, cal_time;
  int fails, check_count;
  logic [15:0] mb [11] = '{16'h3f, 16'h3f, 16'h1f, 16'h7, 16'h1f, 16'hf, 16'hfff,
    16'hbf, 16'h9f, 16'h87, 16'h9f};
  logic [15:0] md [11] = '{16'h7f, 16'h7f, 16'h3f, 16'h7, 16'h3f, 16'h1f, 16'h7fff,
    16'hff, 16'hbf, 16'h87, 16'hbf};
  cafr_regs dut_u (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CNT_LOAD(cnt_load), .CNT_TIME(cnt_time),
    .CAL_TIME(cal_time), .DECIMAL_MODE(dec_mode), .CALENDAR_MODE(cal_mode),
    .ALARM_MATCH(a_match), .ALARM_EVENT(a_event));
  task automatic stop_test();
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sweep(input logic [1:0] c, input logic wr);
    apb(1'b1, OFF_CTRL, {30'h0, c});
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, {30'h0, c});
    chk({31'h0, dec_mode}, {31'h0, c[0] & c[1]});
    for (int i = 0; i < 11; i++) begin
      if (wr) apb(1'b1, OFF_SECONDS + 8'(4 * i), 32'hffffffff);
      apb(1'b0, OFF_SECONDS + 8'(4 * i), 32'h0);
      if (c == 2'b11) begin
        chk(rd, {16'h0, md[i]});
      end else begin
        chk(rd, {16'h0, mb[i]});
      end
    end
  endtask
  task automatic wait_evt(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (6) begin
      @(posedge ref_clk);
      if (a_event === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, {31'h0, e});
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #1000000;
    fails++;
    stop_test();
  end
  initial begin
    {rst_n, psel, penable, pwrite, cnt_load, paddr, pwdata} = '0;
    pstrb = 4'hf;
    cnt_time = '0;
    fails = 0;
    check_count = 0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk({30'h0, cal_mode, dec_mode}, 32'h2);
    sweep(2'b10, 1'b1);
    sweep(2'b11, 1'b1);
    sweep(2'b01, 1'b0);
    apb(1'b0, 8'h34, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h09, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h2);
    apb(1'b1, OFF_MINUTES, 32'h1e);
    apb(1'b1, OFF_ALARM_HOURS, 32'h05);
    apb(1'b1, OFF_ALARM_WEEKDAY, 32'h0);
    apb(1'b1, OFF_ALARM_MONTHDAY, 32'h0);
    apb(1'b1, OFF_ALARM_MINUTES, 32'h1e);
    wait_evt(1'b0);
    apb(1'b1, OFF_ALARM_MINUTES, 32'h9e);
    wait_evt(1'b1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, OFF_ALARM_HOURS, 32'h85);
    wait_evt(1'b0);
    chk({31'h0, a_match}, 32'h0);
    cnt_time <= '{8'h0, 8'h1e, 8'h05, 8'hfe, 8'h0, 8'h0, 16'h0};
    cnt_load <= 1'b1;
    @(posedge ref_clk);
    cnt_load <= 1'b0;
    wait_evt(1'b1);
    chk({24'h0, cal_time.weekday_field_reg}, 32'h6);
    apb(1'b1, OFF_STATUS, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h2);
    stop_test();
  end
endmodule
`default_nettype wire
